/* File: hdl/config_mode_pin_select.sv */
// Configuration mode decoder and shared configuration pin selection.
// Assumes the configuration engine on clk starts and ends each attempt.
//
// Function
// - Mode pins 001, 110 and 111 choose master flash, slave parallel and slave serial.
// - Master flash mode drives one, two, four or eight data lanes.
// - Slave parallel mode takes words of 8, 16 or 32 bits.
// - Slave serial mode takes one bit per configuration clock rising edge.
// - The test access path is enabled for every mode pin value but 000.
// - Mode pins 101 enable only the test access path.
// - The configuration clock pin is driven in flash mode and an input in slave modes.
// - Shared pins take their per-mode roles as lanes, selects and chain output.
module config_mode_pin_select (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] mode_pins,
  input wire logic attempt_start,
  input wire logic attempt_end,
  input wire logic [1:0] flash_width,
  input wire logic [1:0] parallel_width,
  input wire logic flash_clock,
  input wire logic flash_select,
  input wire logic [7:0] flash_lane_drive,
  input wire logic [7:0] flash_lane_oe,
  input wire logic chain_out_data,
  input wire logic config_clock_pin,
  output logic config_clock_pin_drive,
  output logic config_clock_pin_oe,
  input wire logic serial_in_lane1_data_in,
  output logic serial_in_lane1_data_in_drive,
  output logic serial_in_lane1_data_in_oe,
  input wire logic serial_out_lane0,
  output logic serial_out_lane0_drive,
  output logic serial_out_lane0_oe,
  input wire logic [29:0] upper_lanes,
  output logic [29:0] upper_lanes_drive,
  output logic [29:0] upper_lanes_oe,
  output logic chain_select_data_out,
  output logic chain_select_data_out_oe,
  output logic flash_select_n,
  output logic flash_select_n_oe,
  output logic second_flash_select_n,
  output logic second_flash_select_n_oe,
  input wire logic external_config_clock_in,
  input wire logic chip_select_n,
  input wire logic read_write_direction_select,
  output config_mode_pkg::config_mode_e mode,
  output logic attempt_active,
  output logic test_access_enable,
  output logic [7:0] flash_lane_data,
  output logic external_clock_level,
  output logic serial_bit,
  output logic serial_bit_valid,
  output logic [31:0] parallel_word,
  output logic parallel_word_valid
);

  logic [config_mode_pkg::SYNC_WIDTH-1:0] synced;
  logic [2:0] mode_sync;
  logic clock_sync, clock_prev, clock_rise, cs_n_sync, rw_sync;
  logic [31:0] data_sync, width_mask;
  config_mode_pkg::attempt_state_e state;
  config_mode_pkg::config_mode_e next_mode;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(config_mode_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .raw({mode_pins, config_clock_pin, upper_lanes, serial_in_lane1_data_in,
          serial_out_lane0, chip_select_n, read_write_direction_select,
          external_config_clock_in}),
    .synced(synced)
  );

  assign mode_sync = synced[38:36];
  assign clock_sync = synced[35];
  assign data_sync = {synced[34:5], synced[4], synced[3]};
  assign cs_n_sync = synced[2];
  assign rw_sync = synced[1];
  assign external_clock_level = synced[0];
  assign clock_rise = clock_sync && !clock_prev;
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_prev <= 1'b0;
    end else begin
      clock_prev <= clock_sync;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (mode_sync)
      config_mode_pkg::MODE_PINS_NONE: next_mode = config_mode_pkg::MODE_NONE;
      config_mode_pkg::MODE_PINS_FLASH: next_mode = config_mode_pkg::MODE_FLASH;
      config_mode_pkg::MODE_PINS_PARALLEL: next_mode = config_mode_pkg::MODE_PARALLEL;
      config_mode_pkg::MODE_PINS_SERIAL: next_mode = config_mode_pkg::MODE_SERIAL;
      default: next_mode = config_mode_pkg::MODE_TEST_ONLY;
    endcase
  end

  // ----------------------------------------------------------------
  // Attempt tracking and mode hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= config_mode_pkg::ATTEMPT_IDLE;
      mode <= config_mode_pkg::MODE_NONE;
    end else begin
      unique case (state)
        config_mode_pkg::ATTEMPT_IDLE: begin
          if (attempt_start) begin
            state <= config_mode_pkg::ATTEMPT_ACTIVE;
            mode <= next_mode;
          end
        end
        config_mode_pkg::ATTEMPT_ACTIVE: begin
          if (attempt_end) begin
            state <= config_mode_pkg::ATTEMPT_IDLE;
          end
        end
        default: state <= config_mode_pkg::ATTEMPT_IDLE;
      endcase
    end
  end
  assign attempt_active = (state == config_mode_pkg::ATTEMPT_ACTIVE);

  // Test access has priority; only all zeros disables it
  always_ff @(posedge clk) begin
    if (reset) begin
      test_access_enable <= 1'b0;
    end else begin
      test_access_enable <= (mode != config_mode_pkg::MODE_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Pin roles per mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      config_clock_pin_drive <= 1'b0;
      config_clock_pin_oe <= 1'b0;
      serial_out_lane0_drive <= 1'b0;
      serial_out_lane0_oe <= 1'b0;
      serial_in_lane1_data_in_drive <= 1'b0;
      serial_in_lane1_data_in_oe <= 1'b0;
      upper_lanes_drive <= config_mode_pkg::UPPER_RESET;
      upper_lanes_oe <= config_mode_pkg::UPPER_RESET;
      chain_select_data_out <= 1'b0;
      chain_select_data_out_oe <= 1'b0;
      flash_select_n <= 1'b1;
      flash_select_n_oe <= 1'b0;
      second_flash_select_n <= 1'b1;
      second_flash_select_n_oe <= 1'b0;
    end else begin
      config_clock_pin_drive <= flash_clock;
      config_clock_pin_oe <= (mode == config_mode_pkg::MODE_FLASH);
      serial_out_lane0_drive <= flash_lane_drive[0];
      serial_in_lane1_data_in_drive <= flash_lane_drive[1];
      upper_lanes_drive <= {24'h0, flash_lane_drive[7:2]};
      chain_select_data_out <= chain_out_data;
      flash_select_n <= !flash_select;
      second_flash_select_n <= !flash_select;
      serial_out_lane0_oe <= 1'b0;
      serial_in_lane1_data_in_oe <= 1'b0;
      upper_lanes_oe <= config_mode_pkg::UPPER_RESET;
      chain_select_data_out_oe <= 1'b0;
      flash_select_n_oe <= 1'b0;
      second_flash_select_n_oe <= 1'b0;
      if (mode == config_mode_pkg::MODE_FLASH) begin
        flash_select_n_oe <= 1'b1;
        if (flash_width == config_mode_pkg::FLASH_WIDTH_X1) begin
          serial_out_lane0_oe <= 1'b1;
          chain_select_data_out_oe <= 1'b1;
        end else begin
          serial_out_lane0_oe <= flash_lane_oe[0];
          serial_in_lane1_data_in_oe <= flash_lane_oe[1];
        end
        if (flash_width == config_mode_pkg::FLASH_WIDTH_X4 ||
            flash_width == config_mode_pkg::FLASH_WIDTH_X8) begin
          upper_lanes_oe[1:0] <= flash_lane_oe[3:2];
        end
        if (flash_width == config_mode_pkg::FLASH_WIDTH_X8) begin
          upper_lanes_oe[5:2] <= flash_lane_oe[7:4];
          second_flash_select_n_oe <= 1'b1;
        end
      end
      if (mode == config_mode_pkg::MODE_SERIAL || mode == config_mode_pkg::MODE_PARALLEL) begin
        chain_select_data_out_oe <= 1'b1;
      end
    end
  end

  // Flash read lanes, masked to the active width
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_lane_data <= 8'h0;
    end else if (flash_width == config_mode_pkg::FLASH_WIDTH_X1) begin
      flash_lane_data <= {7'h0, data_sync[1]};
    end else if (flash_width == config_mode_pkg::FLASH_WIDTH_X2) begin
      flash_lane_data <= {6'h0, data_sync[1:0]};
    end else if (flash_width == config_mode_pkg::FLASH_WIDTH_X4) begin
      flash_lane_data <= {4'h0, data_sync[3:0]};
    end else begin
      flash_lane_data <= data_sync[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Slave serial capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_bit <= 1'b0;
      serial_bit_valid <= 1'b0;
    end else begin
      serial_bit_valid <= clock_rise && attempt_active &&
                          (mode == config_mode_pkg::MODE_SERIAL);
      if (clock_rise) begin
        serial_bit <= data_sync[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave parallel capture
  // ----------------------------------------------------------------
  always_comb begin
    unique case (parallel_width)
      config_mode_pkg::PAR_WIDTH_X16: width_mask = 32'h0000ffff;
      config_mode_pkg::PAR_WIDTH_X32: width_mask = 32'hffffffff;
      default: width_mask = 32'h000000ff;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      parallel_word <= config_mode_pkg::WORD_RESET;
      parallel_word_valid <= 1'b0;
    end else begin
      parallel_word_valid <= clock_rise && attempt_active && !cs_n_sync && !rw_sync &&
                             (mode == config_mode_pkg::MODE_PARALLEL);
      if (clock_rise) begin
        parallel_word <= data_sync & width_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  mode_decode_a: assert property (@(posedge clk) disable iff (reset)
    (state == config_mode_pkg::ATTEMPT_IDLE) && attempt_start &&
    (mode_sync == config_mode_pkg::MODE_PINS_SERIAL) |=> (mode == config_mode_pkg::MODE_SERIAL))
    else $error("serial mode code not decoded");
  mode_hold_a: assert property (@(posedge clk) disable iff (reset)
    attempt_active && !attempt_end |=> $stable(mode))
    else $error("mode changed inside an attempt");
  clock_dir_a: assert property (@(posedge clk) disable iff (reset)
    config_clock_pin_oe |-> ($past(mode) == config_mode_pkg::MODE_FLASH))
    else $error("clock pin driven outside flash mode");
  test_enable_a: assert property (@(posedge clk) disable iff (reset)
    ##1 (test_access_enable == ($past(mode) != config_mode_pkg::MODE_NONE)))
    else $error("test access enable wrong");
  test_only_a: assert property (@(posedge clk) disable iff (reset)
    (mode == config_mode_pkg::MODE_TEST_ONLY) [*2] |-> !config_clock_pin_oe &&
    !flash_select_n_oe && !chain_select_data_out_oe && !serial_bit_valid)
    else $error("interface enabled in test only mode");
  serial_bit_a: assert property (@(posedge clk) disable iff (reset)
    serial_bit_valid |-> $past(clock_rise) && (serial_bit == $past(data_sync[1])))
    else $error("serial bit not tied to clock edge");
  par_width_a: assert property (@(posedge clk) disable iff (reset)
    parallel_word_valid && $past(parallel_width == config_mode_pkg::PAR_WIDTH_X8) |->
    (parallel_word[31:8] == 24'h0))
    else $error("parallel word wider than eight bits");
  flash_lane_a: assert property (@(posedge clk) disable iff (reset)
    $past(flash_width == config_mode_pkg::FLASH_WIDTH_X2) |-> (upper_lanes_oe == 30'h0))
    else $error("upper lanes driven at two bit width");
  par_pins_a: assert property (@(posedge clk) disable iff (reset)
    (mode == config_mode_pkg::MODE_PARALLEL) |=> !serial_out_lane0_oe &&
    (upper_lanes_oe == 30'h0) && chain_select_data_out_oe)
    else $error("pin roles wrong in parallel mode");

  flash_start_c: cover property (@(posedge clk) disable iff (reset)
    attempt_active && (mode == config_mode_pkg::MODE_FLASH) && config_clock_pin_oe);
  serial_bit_c: cover property (@(posedge clk) disable iff (reset) serial_bit_valid);
  par_word_c: cover property (@(posedge clk) disable iff (reset)
    parallel_word_valid && (parallel_width == config_mode_pkg::PAR_WIDTH_X32));
  test_only_c: cover property (@(posedge clk) disable iff (reset)
    attempt_active && (mode == config_mode_pkg::MODE_TEST_ONLY));

endmodule

/* File: hdl/config_mode_pkg.sv */
// Constants for the configuration mode decoder and shared pin selection.
// Assumes the configuration engine runs on the same 100 MHz clock.
package config_mode_pkg;

  // ----------------------------------------------------------------
  // Mode pin codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_PINS_NONE = 3'h0;
  localparam logic [2:0] MODE_PINS_FLASH = 3'h1;
  localparam logic [2:0] MODE_PINS_TEST_ONLY = 3'h5;
  localparam logic [2:0] MODE_PINS_PARALLEL = 3'h6;
  localparam logic [2:0] MODE_PINS_SERIAL = 3'h7;

  // ----------------------------------------------------------------
  // Decoded modes and attempt states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_NONE = 5'h01,
    MODE_TEST_ONLY = 5'h02,
    MODE_FLASH = 5'h04,
    MODE_PARALLEL = 5'h08,
    MODE_SERIAL = 5'h10
  } config_mode_e;

  typedef enum logic [1:0] {
    ATTEMPT_IDLE = 2'h1,
    ATTEMPT_ACTIVE = 2'h2
  } attempt_state_e;

  // ----------------------------------------------------------------
  // Width selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FLASH_WIDTH_X1 = 2'h0;
  localparam logic [1:0] FLASH_WIDTH_X2 = 2'h1;
  localparam logic [1:0] FLASH_WIDTH_X4 = 2'h2;
  localparam logic [1:0] FLASH_WIDTH_X8 = 2'h3;
  localparam logic [1:0] PAR_WIDTH_X8 = 2'h0;
  localparam logic [1:0] PAR_WIDTH_X16 = 2'h1;
  localparam logic [1:0] PAR_WIDTH_X32 = 2'h2;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam int UPPER_LANES = 30;
  localparam int SYNC_WIDTH = 39;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 39'h0;
  localparam logic [31:0] WORD_RESET = 32'h0;
  localparam logic [UPPER_LANES-1:0] UPPER_RESET = 30'h0;

endpackage

/* File: hdl/pin_sync.sv */
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a level that is held for several clocks.
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] first_stage;

  // ----------------------------------------------------------------
  // Two stages, first read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      first_stage <= '0;
      synced <= '0;
    end else begin
      first_stage <= raw;
      synced <= first_stage;
    end
  end

endmodule

/* File: tb/cfg_host_model.sv */
// Behavioural host at the slave side of the shared configuration pins.
// Assumes the bench resolves each shared pin from the decoder's output enables alone.
module cfg_host_model (
  output logic clk_pin,
  output logic lane1,
  output logic lane0,
  output logic [29:0] upper,
  output logic cs_n,
  output logic rw
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    clk_pin = 1'b0;
    {upper, lane1, lane0} = 32'h0;
    cs_n = 1'b1;
    rw = 1'b1;
  end

  // ----------------------------------------------------------------
  // Clocking tasks
  // ----------------------------------------------------------------
  // Host pulses the clock pin only while sending; mode 000 is strapped only in test_decode
  task automatic send_bit(input logic b);
    lane1 = b;
    #30 clk_pin = 1'b1;
    #62.5 clk_pin = 1'b0;
    lane1 = ~b;
    #32.5;
  endtask

  task automatic send_word(input logic [31:0] w);
    {upper, lane1, lane0} = w;
    cs_n = 1'b0;
    rw = 1'b0;
    #30 clk_pin = 1'b1;
    #62.5 clk_pin = 1'b0;
    {upper, lane1, lane0} = ~w;
    cs_n = 1'b1;
    rw = 1'b1;
    #32.5;
  endtask
endmodule

/* File: tb/config_mode_pin_select_tb.sv */
// Self-checking bench for the configuration mode decoder.
// Assumes the host model stands on the shared pins in slave modes.
module config_mode_pin_select_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0, reset = 1'b1, start = 1'b0, stop = 1'b0, fclk = 1'b0, fsel = 1'b1;
  logic chain = 1'b1, ext_clk = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [1:0] fw = 2'h0, pw = 2'h0;
  logic [7:0] ldrv = 8'h5a, loe = 8'hff;
  wire h_clk, h_l1, h_l0, h_cs_n, h_rw;
  wire [29:0] h_up;
  logic cp_drv, cp_oe, l1_drv, l1_oe, l0_drv, l0_oe, cso, cso_oe, fs_n, fs_oe, fs2_n, fs2_oe;
  logic ext_lvl, sbit, sval, pval, active, tae;
  logic [29:0] up_drv, up_oe;
  logic [7:0] fdata, bits;
  logic [31:0] pword, word;
  int nbits = 0, failures = 0, n_checks = 0;
  config_mode_pkg::config_mode_e mode;
  wire cp_pin = cp_oe ? cp_drv : h_clk;
  wire l1_pin = l1_oe ? l1_drv : h_l1;
  wire l0_pin = l0_oe ? l0_drv : h_l0;
  wire [29:0] up_pin = (up_oe & up_drv) | (~up_oe & h_up);

  always #5 clk = ~clk;

  cfg_host_model i_host (.clk_pin(h_clk), .lane1(h_l1), .lane0(h_l0), .upper(h_up),
    .cs_n(h_cs_n), .rw(h_rw));

  config_mode_pin_select i_dut (.clk(clk), .reset(reset), .mode_pins(pins),
    .attempt_start(start), .attempt_end(stop), .flash_width(fw), .parallel_width(pw),
    .flash_clock(fclk), .flash_select(fsel), .flash_lane_drive(ldrv), .flash_lane_oe(loe),
    .chain_out_data(chain), .config_clock_pin(cp_pin), .config_clock_pin_drive(cp_drv),
    .config_clock_pin_oe(cp_oe), .serial_in_lane1_data_in(l1_pin),
    .serial_in_lane1_data_in_drive(l1_drv), .serial_in_lane1_data_in_oe(l1_oe),
    .serial_out_lane0(l0_pin), .serial_out_lane0_drive(l0_drv), .serial_out_lane0_oe(l0_oe),
    .upper_lanes(up_pin), .upper_lanes_drive(up_drv), .upper_lanes_oe(up_oe),
    .chain_select_data_out(cso), .chain_select_data_out_oe(cso_oe), .flash_select_n(fs_n),
    .flash_select_n_oe(fs_oe), .second_flash_select_n(fs2_n),
    .second_flash_select_n_oe(fs2_oe), .external_config_clock_in(ext_clk),
    .chip_select_n(h_cs_n), .read_write_direction_select(h_rw), .mode(mode),
    .attempt_active(active), .test_access_enable(tae), .flash_lane_data(fdata),
    .external_clock_level(ext_lvl), .serial_bit(sbit), .serial_bit_valid(sval),
    .parallel_word(pword), .parallel_word_valid(pval));

  // ----------------------------------------------------------------
  // Capture of one-cycle results
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sval === 1'b1) begin
      bits <= {bits[6:0], sbit};
      nbits <= nbits + 1;
    end
    if (pval === 1'b1) word <= pword;
  end

  // ----------------------------------------------------------------
  // Compare and control tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_mode(input config_mode_pkg::config_mode_e exp);
    n_checks++;
    if (mode !== exp) begin
      failures++;
      $display("Error at %0t: mode %h expected %h", $time, mode, exp);
    end
  endtask

  task automatic begin_attempt(input logic [2:0] code);
    pins = code;
    repeat (3) @(negedge clk);
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic end_attempt();
    stop = 1'b1;
    @(negedge clk) stop = 1'b0;
    @(negedge clk);
  endtask

  function automatic config_mode_pkg::config_mode_e exp_mode(input logic [2:0] c);
    case (c)
      3'h0: return config_mode_pkg::MODE_NONE;
      3'h1: return config_mode_pkg::MODE_FLASH;
      3'h6: return config_mode_pkg::MODE_PARALLEL;
      3'h7: return config_mode_pkg::MODE_SERIAL;
      default: return config_mode_pkg::MODE_TEST_ONLY;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_decode();
    for (int c = 0; c < 8; c++) begin
      begin_attempt(c[2:0]);
      chk_mode(exp_mode(c[2:0]));
      chk(tae, c != 0);
      chk(cp_oe, c == 1);
      chk(cso_oe, c == 1 || c >= 6);
      chk(active, 1'b1);
      end_attempt();
      chk(active, 1'b0);
    end
    $display("Test decode done");
  endtask

  task automatic test_hold();
    begin_attempt(3'h7);
    pins = 3'h1;
    repeat (5) @(negedge clk);
    chk_mode(config_mode_pkg::MODE_SERIAL);
    end_attempt();
    chk_mode(config_mode_pkg::MODE_SERIAL);
    begin_attempt(3'h1);
    chk_mode(config_mode_pkg::MODE_FLASH);
    end_attempt();
    $display("Test hold done");
  endtask

  task automatic test_flash();
    logic [29:0] up_exp [4] = '{30'h0, 30'h0, 30'h3, 30'h3f};
    logic [7:0] fd_exp [4] = '{8'h0, 8'h2, 8'ha, 8'h5a};
    for (int w = 0; w < 4; w++) begin
      fw = w[1:0];
      begin_attempt(3'h1);
      fclk = w[0];
      ext_clk = ~w[0];
      repeat (3) @(negedge clk);
      chk(cp_oe, 1'b1);
      chk(cp_drv, w[0]);
      chk(l0_oe, 1'b1);
      chk(l1_oe, w != 0);
      chk(cso_oe, w == 0);
      chk(up_oe, up_exp[w]);
      chk(fs2_oe, w == 3);
      chk(fs_n, 1'b0);
      chk(fs_oe, 1'b1);
      chk(fs2_n, 1'b0);
      chk(cso, 1'b1);
      chk(fdata, fd_exp[w]);
      chk(ext_lvl, !w[0]);
      end_attempt();
    end
    $display("Test flash done");
  endtask

  task automatic test_serial();
    int n0;
    logic [7:0] pat = 8'ha5;
    begin_attempt(3'h7);
    n0 = nbits;
    chk(cp_oe, 1'b0);
    chk(cso_oe, 1'b1);
    chk(l1_oe, 1'b0);
    for (int i = 7; i >= 0; i--) i_host.send_bit(pat[i]);
    repeat (4) @(negedge clk);
    chk(bits, 8'ha5);
    chk(nbits - n0, 8);
    end_attempt();
    $display("Test serial done");
  endtask

  task automatic test_parallel();
    logic [31:0] m [3] = '{32'hff, 32'hffff, 32'hffffffff};
    int n0;
    n0 = nbits;
    for (int w = 0; w < 3; w++) begin
      pw = w[1:0];
      begin_attempt(3'h6);
      chk(cp_oe, 1'b0);
      chk(up_oe, 30'h0);
      i_host.send_word(32'hdeadbeef + w);
      repeat (4) @(negedge clk);
      chk(word, (32'hdeadbeef + w) & m[w]);
      end_attempt();
    end
    chk(nbits - n0, 0);
    $display("Test parallel done");
  endtask

  task automatic end_sim();
    $display("Checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200us;
    failures++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    repeat (4) @(negedge clk);
    chk_mode(config_mode_pkg::MODE_NONE);
    chk(fs_n, 1'b1);
    chk(cp_oe, 1'b0);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    test_decode();
    test_hold();
    test_flash();
    test_serial();
    test_parallel();
    end_sim();
  end
endmodule
